/* mcc_addr_map.sv */
// data address resolution for file-register operands
`timescale 1ns/1ps
module mcc_addr_map (
  input  mcc_pkg::mcc_decode_t dec,      // decoded instruction
  input  wire logic [3:0]      bank,     // bank select low nibble
  input  wire logic [11:0]     index,    // literal offset base pointer
  input  wire logic            ext_en,   // extended set enabled
  output logic [11:0]          eff_addr  // resolved data address
);
  import mcc_pkg::*;

  always_comb begin
    if (dec.a) begin
      eff_addr = {bank, dec.f};
    end else if (ext_en && dec.f <= ILO_LIMIT) begin
      eff_addr = index + {4'h0, dec.f};
    end else if (dec.f < ACCESS_SPLIT) begin
      eff_addr = {4'h0, dec.f};
    end else begin
      eff_addr = {SFR_BANK, dec.f};
    end
  end
endmodule

/* mcc_core.sv */
// opcode execution core with avalon-mm register access
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module mcc_core #(
  parameter int WDT_DIV = mcc_pkg::WDT_TICK_CYC, // clocks per watchdog tick
  parameter int Q_DIV   = mcc_pkg::QUARTER_CYC   // clocks per quarter
) (
  input  wire logic        clk,              // 25 mhz core clock
  input  wire logic        sys_rst,          // sync reset, high
  input  wire logic [7:0]  address,          // avalon byte address
  input  wire logic        read,             // avalon read
  input  wire logic        write,            // avalon write
  input  wire logic [31:0] writedata,        // avalon write data
  output logic [31:0]      readdata,         // avalon read data
  output logic             waitrequest,      // avalon wait
  output logic             timeout_flag_n,   // low after time-out
  output logic             powerdown_flag_n  // low after power-down
);
  import mcc_pkg::*;

  mcc_state_t  state;
  mcc_decode_t dec;
  logic [15:0] instr;
  logic [11:0] eff_addr;
  logic [7:0]  operand;
  logic [7:0]  result;
  logic [7:0]  wreg;
  logic [7:0]  bank_select_reg;
  logic [7:0]  status;
  logic [7:0]  work_shadow;
  logic [7:0]  bank_select_shadow;
  logic [7:0]  status_shadow;
  logic [20:0] pc;
  logic [20:0] stack_top;
  logic [11:0] index;
  logic [11:0] mem_addr;
  logic [7:0]  call_low;
  logic        call_pend;
  logic        ext_en;
  logic        skip;
  logic        discard;
  logic        equal;
  logic        ack;
  logic        busy;
  logic        bus_ok;
  logic        bus_wr;
  logic        mem_we;
  logic        q_en;
  logic        wdt_tick;
  logic        wdt_clear;
  logic        wdt_expire;
  logic [31:0] rd_mux;
  logic [7:0]  dmem [0:4095];
  logic [$clog2(Q_DIV+1)-1:0]   q_cnt;
  logic [$clog2(WDT_DIV+1)-1:0] w_cnt;
  logic [WDT_CNT_W-1:0]         watchdog_counter;
  logic [WDT_POST_W-1:0]        wdt_post;

  assign busy   = (state != ST_IDLE);
  assign bus_ok = !(write && busy);
  assign bus_wr = write && ack;
  assign mem_we = !discard && ((dec.kind == op_clear_file) ||
                  (dec.kind == op_invert_file && dec.d));

  mcc_addr_map u_addr (
    .dec      (dec),
    .bank     (bank_select_reg[3:0]),
    .index    (index),
    .ext_en   (ext_en),
    .eff_addr (eff_addr)
  );

  mcc_watchdog #(
    .CNT_W  (WDT_CNT_W),
    .POST_W (WDT_POST_W)
  ) u_wdt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (wdt_tick),
    .clear   (wdt_clear),
    .count   (watchdog_counter),
    .post    (wdt_post),
    .expire  (wdt_expire)
  );

  // quarter and watchdog enable dividers
  always_ff @(posedge clk) begin
    if (sys_rst || q_cnt == Q_DIV[$bits(q_cnt)-1:0] - 1'b1) begin
      q_cnt <= '0;
    end else begin
      q_cnt <= q_cnt + 1'b1;
    end
  end
  assign q_en = (q_cnt == Q_DIV[$bits(q_cnt)-1:0] - 1'b1);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_cnt    <= '0;
      wdt_tick <= 1'b0;
    end else if (w_cnt == WDT_DIV[$bits(w_cnt)-1:0] - 1'b1) begin
      w_cnt    <= '0;
      wdt_tick <= 1'b1;
    end else begin
      w_cnt    <= w_cnt + 1'b1;
      wdt_tick <= 1'b0;
    end
  end

  // bus slave: one cycle of waitrequest low per accepted access;
  // writes wait while an instruction runs so no register is shared
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack         <= 1'b0;
      waitrequest <= 1'b1;
      readdata    <= '0;
    end else if (ack) begin
      ack         <= 1'b0;
      waitrequest <= 1'b1;
    end else if ((read || write) && bus_ok) begin
      ack         <= 1'b1;
      waitrequest <= 1'b0;
      if (read) begin
        readdata <= rd_mux;
      end
    end
  end

  always_comb begin
    if (address == OFF_INSTR) begin
      rd_mux = {16'h0000, instr};
    end else if (address == OFF_CTRL) begin
      rd_mux = {31'h00000000, ext_en};
    end else if (address == OFF_WREG) begin
      rd_mux = {24'h000000, wreg};
    end else if (address == OFF_BANK) begin
      rd_mux = {24'h000000, bank_select_reg};
    end else if (address == OFF_STATUS) begin
      rd_mux = {24'h000000, status};
    end else if (address == OFF_SHADOW) begin
      rd_mux = {8'h00, status_shadow, bank_select_shadow, work_shadow};
    end else if (address == OFF_PC) begin
      rd_mux = {11'h000, pc};
    end else if (address == OFF_STKTOP) begin
      rd_mux = {11'h000, stack_top};
    end else if (address == OFF_INDEX) begin
      rd_mux = {20'h00000, index};
    end else if (address == OFF_MADDR) begin
      rd_mux = {20'h00000, mem_addr};
    end else if (address == OFF_MDATA) begin
      rd_mux = {24'h000000, dmem[mem_addr]};
    end else if (address == OFF_WDOG) begin
      rd_mux = {14'h0000, powerdown_flag_n, timeout_flag_n, 4'h0,
                wdt_post, watchdog_counter};
    end else if (address == OFF_CORE) begin
      rd_mux = {29'h00000000, skip, call_pend, busy};
    end else begin
      rd_mux = '0;
    end
  end

  // quarter sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: if (bus_wr && address == OFF_INSTR) state <= ST_Q1;
        ST_Q1:   if (q_en) state <= ST_Q2;
        ST_Q2:   if (q_en) state <= ST_Q3;
        ST_Q3:   if (q_en) state <= ST_Q4;
        ST_Q4:   if (q_en) state <= ST_IDLE;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Q1: decode; a word fetched under a pending skip is discarded
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      instr   <= RST_INSTR;
      dec     <= mcc_decode(RST_INSTR, 1'b0);
      discard <= 1'b0;
    end else if (state == ST_IDLE && bus_wr && address == OFF_INSTR) begin
      instr <= writedata[15:0];
    end else if (state == ST_Q1 && q_en) begin
      dec     <= mcc_decode(instr, call_pend);
      discard <= skip;
    end
  end

  // Q2 read, Q3 process
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      operand <= RST_BYTE;
      result  <= RST_BYTE;
      equal   <= 1'b0;
    end else if (state == ST_Q2 && q_en) begin
      operand <= dmem[eff_addr];
    end else if (state == ST_Q3 && q_en) begin
      if (dec.kind == op_invert_file) begin
        result <= ~operand;
      end else begin
        result <= RST_BYTE;
      end
      equal <= (operand - wreg) == 8'h00;
    end
  end

  // Q4 data memory write, or software access when idle
  always_ff @(posedge clk) begin
    if (state == ST_Q4 && q_en && mem_we) begin
      dmem[eff_addr] <= result;
    end else if (!busy && bus_wr && address == OFF_MDATA) begin
      dmem[mem_addr] <= writedata[7:0];
    end
  end

  assign wdt_clear = state == ST_Q3 && q_en && !discard &&
                     dec.kind == op_clear_watchdog;

  // time-out wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else begin
      if (wdt_expire) begin
        timeout_flag_n <= 1'b0;
      end else if (wdt_clear) begin
        timeout_flag_n <= 1'b1;
      end
      if (wdt_clear) begin
        powerdown_flag_n <= 1'b1;
      end else if (bus_wr && address == OFF_WDOG &&
                   !writedata[WDOG_PDN_BIT]) begin
        powerdown_flag_n <= 1'b0;
      end
    end
  end

  // working, bank, status and shadow registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wreg               <= RST_BYTE;
      bank_select_reg    <= RST_BYTE;
      status             <= RST_BYTE;
      work_shadow        <= RST_BYTE;
      bank_select_shadow <= RST_BYTE;
      status_shadow      <= RST_BYTE;
      ext_en             <= 1'b0;
      index              <= RST_INDEX;
      mem_addr           <= RST_INDEX;
    end else if (!busy && bus_wr) begin
      if (address == OFF_WREG) wreg <= writedata[7:0];
      if (address == OFF_BANK) bank_select_reg <= writedata[7:0];
      if (address == OFF_STATUS) status <= writedata[7:0];
      if (address == OFF_CTRL) ext_en <= writedata[CTRL_EXT];
      if (address == OFF_INDEX) index <= writedata[11:0];
      if (address == OFF_MADDR) mem_addr <= writedata[11:0];
    end else if (state == ST_Q3 && q_en && !discard &&
                 dec.kind == op_call_low && dec.s) begin
      work_shadow        <= wreg;
      bank_select_shadow <= bank_select_reg;
      status_shadow      <= status;
    end else if (state == ST_Q4 && q_en && !discard) begin
      if (dec.kind == op_clear_file) begin
        status[ST_Z_BIT] <= 1'b1;
      end else if (dec.kind == op_invert_file) begin
        status[ST_N_BIT] <= result[7];
        status[ST_Z_BIT] <= result == 8'h00;
        if (!dec.d) wreg <= result;
      end
    end
  end

  // program flow: pc, stack top, skip and call second word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc        <= RST_PC;
      stack_top <= RST_PC;
      skip      <= 1'b0;
      call_pend <= 1'b0;
      call_low  <= RST_BYTE;
    end else if (!busy && bus_wr && address == OFF_PC) begin
      pc <= writedata[20:0];
    end else if (state == ST_Q3 && q_en && !discard &&
                 dec.kind == op_call_low) begin
      stack_top <= pc + PC_RETURN;
      call_low  <= dec.f;
    end else if (state == ST_Q4 && q_en) begin
      if (discard) begin
        pc        <= pc + PC_WORD;
        skip      <= mcc_two_word(instr);
        call_pend <= 1'b0;
      end else if (dec.kind == op_call_high) begin
        pc        <= {instr[11:0], call_low, 1'b0};
        call_pend <= 1'b0;
      end else begin
        pc        <= pc + PC_WORD;
        skip      <= dec.kind == op_compare_skip_equal && equal;
        call_pend <= dec.kind == op_call_low;
      end
    end
  end
endmodule

/* mcc_core_checker.sv */
// concurrent checks on the execution core's bus and flag ports
`timescale 1ns/1ps
module mcc_core_checker
  import mcc_pkg::*;
#(
  parameter int WDT_DIV = 4,
  parameter int Q_DIV   = 1
) (
  input wire logic        clk,              // core clock
  input wire logic        sys_rst,          // sync reset, high
  input wire logic [7:0]  address,          // avalon byte address
  input wire logic        read,             // avalon read
  input wire logic        write,            // avalon write
  input wire logic [31:0] writedata,        // avalon write data
  input wire logic [31:0] readdata,         // avalon read data
  input wire logic        waitrequest,      // avalon wait
  input wire logic        timeout_flag_n,   // low after time-out
  input wire logic        powerdown_flag_n  // low after power-down
);
  import mcc_pkg::*;

  // cycles since the last instruction write was answered, saturating
  logic [7:0] since_instr;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      since_instr <= 8'hff;
    end else if (write && !waitrequest && address == OFF_INSTR) begin
      since_instr <= 8'h00;
    end else if (since_instr != 8'hff) begin
      since_instr <= since_instr + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("bus answer lasted more than one cycle");
  a_ack_cause: assert property (!waitrequest |-> $past(read || write))
    else $error("bus answer without a request");
  a_read_prompt: assert property ($rose(read) |=> !waitrequest)
    else $error("read not answered on the next cycle");
  // writes are held off while an instruction runs, 4 quarters of Q_DIV
  a_write_bounded: assert property ($rose(write) |-> ##[1:40] !waitrequest)
    else $error("write never answered");
  a_rdata_hold: assert property (!(read && !waitrequest) |-> $stable(readdata))
    else $error("read data moved outside a read answer");
  a_unmapped_zero: assert property
    (read && !waitrequest && address > OFF_CORE |-> readdata == 32'h0)
    else $error("unmapped read returned nonzero");
  a_wreg_upper: assert property
    (read && !waitrequest && address == OFF_WREG |-> readdata[31:8] == 24'h0)
    else $error("working register read has upper bits set");
  a_pd_clear: assert property ($fell(powerdown_flag_n) |->
    $past(write && !waitrequest && address == OFF_WDOG &&
          !writedata[WDOG_PDN_BIT]))
    else $error("powerdown flag fell without a clearing write");
  a_flags_set: assert property (($rose(timeout_flag_n) ||
    $rose(powerdown_flag_n)) |-> since_instr < 8'h28)
    else $error("status flags set outside an instruction");

  cover property (read && !waitrequest);
  cover property ($fell(timeout_flag_n));
  cover property ($rose(powerdown_flag_n));
endmodule

bind mcc_core mcc_core_checker #(.WDT_DIV(WDT_DIV), .Q_DIV(Q_DIV)) i_chk (
  .clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
  .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .timeout_flag_n(timeout_flag_n),
  .powerdown_flag_n(powerdown_flag_n)
);

/* mcc_pkg.sv */
// package: constants, types and decode helpers for the opcode execution core
package mcc_pkg;

  // avalon register map, byte addresses
  localparam logic [7:0] OFF_INSTR   = 8'h00;
  localparam logic [7:0] OFF_CTRL    = 8'h04;
  localparam logic [7:0] OFF_WREG    = 8'h08;
  localparam logic [7:0] OFF_BANK    = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_SHADOW  = 8'h14;
  localparam logic [7:0] OFF_PC      = 8'h18;
  localparam logic [7:0] OFF_STKTOP  = 8'h1c;
  localparam logic [7:0] OFF_INDEX   = 8'h20;
  localparam logic [7:0] OFF_MADDR   = 8'h24;
  localparam logic [7:0] OFF_MDATA   = 8'h28;
  localparam logic [7:0] OFF_WDOG    = 8'h2c;
  localparam logic [7:0] OFF_CORE    = 8'h30;

  // field positions
  localparam int ST_N_BIT     = 4;
  localparam int ST_Z_BIT     = 2;
  localparam int CTRL_EXT     = 0;
  localparam int WDOG_TMO_BIT = 16;
  localparam int WDOG_PDN_BIT = 17;

  // reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [20:0] RST_PC    = 21'h000000;
  localparam logic [11:0] RST_INDEX = 12'h000;
  localparam logic [15:0] RST_INSTR = 16'h0000;

  // addressing
  localparam logic [7:0]  ILO_LIMIT   = 8'h5f;
  localparam logic [3:0]  SFR_BANK    = 4'hf;
  localparam logic [7:0]  ACCESS_SPLIT = 8'h60;

  // opcodes
  localparam logic [6:0]  PAT_CLEAR_FILE = 7'b0110101;
  localparam logic [5:0]  PAT_INVERT     = 6'b000111;
  localparam logic [6:0]  PAT_CMP_SKIP   = 7'b0110001;
  localparam logic [6:0]  PAT_CALL       = 7'b1110110;
  localparam logic [15:0] PAT_CLEAR_WDT  = 16'h0004;
  localparam logic [3:0]  PAT_GOTO_HI    = 4'hf;
  localparam logic [7:0]  PAT_GOTO       = 8'hef;
  localparam logic [7:0]  PAT_LOAD_IDX   = 8'hee;
  localparam logic [3:0]  PAT_MOVE_FF    = 4'hc;

  // program counter steps
  localparam logic [20:0] PC_WORD   = 21'h000002;
  localparam logic [20:0] PC_RETURN = 21'h000004;

  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int WDT_TICK_NS   = 1000000;
  localparam int WDT_TICK_CYC  = WDT_TICK_NS / CLK_PERIOD_NS;
  localparam int QUARTER_CYC   = 1;
  localparam int WDT_CNT_W     = 8;
  localparam int WDT_POST_W    = 4;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_Q1   = 5'b00010,
    ST_Q2   = 5'b00100,
    ST_Q3   = 5'b01000,
    ST_Q4   = 5'b10000
  } mcc_state_t;

  typedef enum logic [6:0] {
    op_none               = 7'b0000001,
    op_clear_file         = 7'b0000010,
    op_clear_watchdog     = 7'b0000100,
    op_invert_file        = 7'b0001000,
    op_compare_skip_equal = 7'b0010000,
    op_call_low           = 7'b0100000,
    op_call_high          = 7'b1000000
  } mcc_kind_t;

  typedef struct packed {
    mcc_kind_t  kind;
    logic       a;
    logic       d;
    logic       s;
    logic [7:0] f;
  } mcc_decode_t;

  function automatic logic mcc_two_word(input logic [15:0] w);
    return (w[15:9] == PAT_CALL) || (w[15:8] == PAT_GOTO) ||
           (w[15:8] == PAT_LOAD_IDX) || (w[15:12] == PAT_MOVE_FF);
  endfunction

  function automatic mcc_decode_t mcc_decode(input logic [15:0] w,
                                             input logic call_pend);
    mcc_decode_t r;
    r.kind = op_none;
    r.a    = w[8];
    r.d    = w[9];
    r.s    = w[8];
    r.f    = w[7:0];
    if (call_pend && w[15:12] == PAT_GOTO_HI) begin
      r.kind = op_call_high;
    end else if (w[15:9] == PAT_CLEAR_FILE) begin
      r.kind = op_clear_file;
    end else if (w == PAT_CLEAR_WDT) begin
      r.kind = op_clear_watchdog;
    end else if (w[15:10] == PAT_INVERT) begin
      r.kind = op_invert_file;
    end else if (w[15:9] == PAT_CMP_SKIP) begin
      r.kind = op_compare_skip_equal;
    end else if (w[15:9] == PAT_CALL) begin
      r.kind = op_call_low;
    end
    return r;
  endfunction

endpackage

/* mcc_watchdog.sv */
// watchdog counter with postscaler
`timescale 1ns/1ps
module mcc_watchdog #(
  parameter int CNT_W  = 8,
  parameter int POST_W = 4
) (
  input  wire logic              clk,     // core clock
  input  wire logic              sys_rst, // sync reset, high
  input  wire logic              tick,    // count enable pulse
  input  wire logic              clear,   // clear pulse
  output logic [CNT_W-1:0]       count,   // counter value
  output logic [POST_W-1:0]      post,    // postscaler value
  output logic                   expire   // one-cycle time-out pulse
);
  import mcc_pkg::*;

  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      count <= '0;
      post  <= '0;
    end else if (tick) begin
      count <= count + 1'b1;
      if (&count) begin
        post <= post + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || clear) begin
      expire <= 1'b0;
    end else begin
      expire <= tick && (&count) && (&post);
    end
  end
endmodule

/* testbench.sv */
// self-checking bench for the opcode execution core
`timescale 1ns/1ps
module testbench;
  import mcc_pkg::*;
  typedef struct packed {
    logic [15:0] instr;
    logic        ext;
    logic [11:0] addr;
    logic [7:0]  m0;
    logic [7:0]  exp_m;
    logic [7:0]  exp_w;
    logic [7:0]  exp_st;
  } mcc_row_t;
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic [7:0]  address = 8'h00;
  logic        read = 1'h0;
  logic        write = 1'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        timeout_flag_n;
  logic        powerdown_flag_n;
  logic [31:0] q;
  logic [31:0] pc0;
  logic [31:0] tos0;
  int          miscompares = 0;
  int          checked = 0;
  // bank 3, index base 200, w 13, status 11 before each row
  mcc_row_t    rows [10] = '{
    '{16'h6a70, 1'h0, 12'hf70, 8'h5a, 8'h00, 8'h13, 8'h15},
    '{16'h6b22, 1'h0, 12'h322, 8'h5a, 8'h00, 8'h13, 8'h15},
    '{16'h6a22, 1'h0, 12'h022, 8'h5a, 8'h00, 8'h13, 8'h15},
    '{16'h6a22, 1'h1, 12'h222, 8'h5a, 8'h00, 8'h13, 8'h15},
    '{16'h6a5f, 1'h1, 12'h25f, 8'h5a, 8'h00, 8'h13, 8'h15},
    '{16'h6a60, 1'h1, 12'hf60, 8'h5a, 8'h00, 8'h13, 8'h15},
    '{16'h1f10, 1'h0, 12'h310, 8'h13, 8'hec, 8'h13, 8'h11},
    '{16'h1d11, 1'h0, 12'h311, 8'h13, 8'h13, 8'hec, 8'h11},
    '{16'h1f12, 1'h0, 12'h312, 8'hff, 8'h00, 8'h13, 8'h05},
    '{16'h1f13, 1'h0, 12'h313, 8'h80, 8'h7f, 8'h13, 8'h01}
  };

  mcc_core #(.WDT_DIV(4), .Q_DIV(4)) i_dut (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .address          (address),
    .read             (read),
    .write            (write),
    .writedata        (writedata),
    .readdata         (readdata),
    .waitrequest      (waitrequest),
    .timeout_flag_n   (timeout_flag_n),
    .powerdown_flag_n (powerdown_flag_n)
  );

  always #20 clk = ~clk;

  // entered just after an edge; holds the request until answered,
  // a hang is left to the watchdog process
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
    read <= ~wr;
    write <= wr;
    address <= a;
    writedata <= d;
    @(posedge clk);
    while (waitrequest !== 1'h0) begin
      @(posedge clk);
    end
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    @(posedge clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic poke(input logic [11:0] a, input logic [7:0] b);
    xfer(1'h1, OFF_MADDR, {20'h0, a});
    xfer(1'h1, OFF_MDATA, {24'h0, b});
  endtask

  task automatic peek(input logic [11:0] a);
    xfer(1'h1, OFF_MADDR, {20'h0, a});
    xfer(1'h0, OFF_MDATA, 32'h0);
  endtask

  // reads are not held off, so poll the busy bit
  task automatic idle;
    int n;
    n = 0;
    xfer(1'h0, OFF_CORE, 32'h0);
    while (q[0] !== 1'h0 && n < 20) begin
      xfer(1'h0, OFF_CORE, 32'h0);
      n++;
    end
    if (q[0] !== 1'h0) miscompares++;
  endtask

  task automatic exec(input logic [15:0] w);
    xfer(1'h1, OFF_INSTR, {16'h0, w});
    idle();
  endtask

  task automatic complete_run;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #(40 * 40000);
    miscompares++;
    complete_run();
  end

  initial begin
    int n;
    repeat (6) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    chk({30'h0, timeout_flag_n, powerdown_flag_n}, 32'h3);
    rdchk(OFF_STATUS, 32'h0);
    rdchk(OFF_PC, 32'h0);
    rdchk(8'h34, 32'h0);
    xfer(1'h1, 8'h34, 32'hffffffff);
    rdchk(8'h34, 32'h0);
    xfer(1'h1, OFF_CORE, 32'h7);
    rdchk(OFF_CORE, 32'h0);
    xfer(1'h1, OFF_BANK, 32'h3);
    xfer(1'h1, OFF_INDEX, 32'h200);
    foreach (rows[i]) begin
      xfer(1'h1, OFF_CTRL, {31'h0, rows[i].ext});
      xfer(1'h1, OFF_WREG, 32'h13);
      xfer(1'h1, OFF_STATUS, 32'h11);
      poke(rows[i].addr, rows[i].m0);
      exec(rows[i].instr);
      peek(rows[i].addr);
      chk(q, {24'h0, rows[i].exp_m});
      rdchk(OFF_WREG, {24'h0, rows[i].exp_w});
      rdchk(OFF_STATUS, {24'h0, rows[i].exp_st});
    end
    // equal compare discards the following clear
    xfer(1'h1, OFF_CTRL, 32'h0);
    xfer(1'h1, OFF_WREG, 32'h13);
    xfer(1'h1, OFF_STATUS, 32'h11);
    poke(12'h040, 8'h13);
    poke(12'h041, 8'h77);
    xfer(1'h0, OFF_PC, 32'h0);
    pc0 = q;
    xfer(1'h1, OFF_INSTR, 32'h6240);
    xfer(1'h0, OFF_CORE, 32'h0);
    chk({31'h0, q[0]}, 32'h1);
    idle();
    rdchk(OFF_CORE, 32'h4);
    rdchk(OFF_STATUS, 32'h11);
    rdchk(OFF_WREG, 32'h13);
    exec(16'h6a41);
    peek(12'h041);
    chk(q, 32'h77);
    peek(12'h040);
    chk(q, 32'h13);
    rdchk(OFF_PC, pc0 + 32'h4);
    xfer(1'h1, OFF_WREG, 32'h14);
    exec(16'h6240);
    rdchk(OFF_CORE, 32'h0);
    exec(16'h6a41);
    peek(12'h041);
    chk(q, 32'h0);
    // skipped call loses both of its words
    xfer(1'h1, OFF_WREG, 32'h13);
    xfer(1'h0, OFF_STKTOP, 32'h0);
    tos0 = q;
    xfer(1'h0, OFF_PC, 32'h0);
    pc0 = q;
    exec(16'h6240);
    exec(16'hec10);
    exec(16'hf001);
    rdchk(OFF_PC, pc0 + 32'h6);
    rdchk(OFF_STKTOP, tos0);
    rdchk(OFF_CORE, 32'h0);
    // call with shadow save
    xfer(1'h1, OFF_PC, 32'h100);
    xfer(1'h1, OFF_WREG, 32'h5a);
    xfer(1'h1, OFF_BANK, 32'h7);
    xfer(1'h1, OFF_STATUS, 32'h11);
    exec(16'hed34);
    exec(16'hf012);
    rdchk(OFF_PC, 32'h2468);
    rdchk(OFF_STKTOP, 32'h104);
    rdchk(OFF_SHADOW, 32'h11075a);
    // let the watchdog expire, then clear it
    for (n = 0; n < 20000 && timeout_flag_n !== 1'h0; n++) @(posedge clk);
    chk({31'h0, timeout_flag_n}, 32'h0);
    xfer(1'h1, OFF_WDOG, 32'h0);
    chk({31'h0, powerdown_flag_n}, 32'h0);
    exec(PAT_CLEAR_WDT);
    chk({30'h0, timeout_flag_n, powerdown_flag_n}, 32'h3);
    xfer(1'h0, OFF_WDOG, 32'h0);
    chk({26'h0, q[17:16], q[11:8]}, 32'h30);
    chk({31'h0, q[7:0] < 8'h10}, 32'h1);
    complete_run();
  end
endmodule
